// ==== rtl/hdm_calc.sv ====
// Purpose: Serial distortion ratio, power or amplitude, in 0.01 % units
// Assumes: A new start only while idle
// Notes:   81 cycles from start to done, 1 cycle for zero fundamental
`timescale 1ns/10ps
`default_nettype none
module hdm_calc (
  input wire logic    clk_in,
  input wire logic    rst_n_in,
  hdm_calc_if.calc    cif
);
  typedef enum logic [1:0] {
    C_IDLE = 2'b00, C_DIV = 2'b01, C_SQRT = 2'b11, C_DONE = 2'b10
  } hdm_cst_t;
  typedef struct packed {
    hdm_cst_t    st;
    logic        pow;
    logic [6:0]  cnt;
    logic [32:0] rem;
    logic [63:0] num;
    logic [31:0] den;
    logic [31:0] op;
    logic [31:0] res;
    logic [31:0] one;
    logic [15:0] out;
  } hdm_calc_t;
  hdm_calc_t   q;
  hdm_calc_t   d;
  logic [32:0] r;
  logic [31:0] fsq;
  logic [31:0] ro;
  // ******************************
  // Next state
  // ******************************
  always_comb begin
    d   = q;
    r   = {q.rem[31:0], q.num[63]};
    fsq = 32'(cif.fund) * 32'(cif.fund);
    ro  = q.res + q.one;
    unique case (q.st)
      C_IDLE: begin
        if (cif.start) begin
          d.pow = cif.power;
          d.den = fsq;
          d.rem = '0;
          d.cnt = '0;
          if (fsq == 32'h0) begin
            d.out = '0;
            d.st  = C_DONE;
          end else begin
            d.num = 64'(cif.sum) * (cif.power ? hdm_pkg::SCALE_POW : hdm_pkg::SCALE_AMP);
            d.st  = C_DIV;
          end
        end
      end
      C_DIV: begin
        d.num = {q.num[62:0], 1'b0};
        if (r >= {1'b0, q.den}) begin
          d.rem    = r - {1'b0, q.den};
          d.num[0] = 1'b1;
        end else begin
          d.rem = r;
        end
        d.cnt = q.cnt + 7'h01;
        if (q.cnt == hdm_pkg::DIV_LAST) begin
          d.st  = C_SQRT;
          d.cnt = '0;
          d.op  = (|d.num[63:32]) ? 32'hffff_ffff : d.num[31:0];
          d.res = '0;
          d.one = hdm_pkg::SQRT_ONE;
        end
      end
      C_SQRT: begin
        if (q.op >= ro) begin
          d.op  = q.op - ro;
          d.res = (q.res >> 1) + q.one;
        end else begin
          d.res = q.res >> 1;
        end
        d.one = q.one >> 2;
        d.cnt = q.cnt + 7'h01;
        if (q.cnt == hdm_pkg::SQRT_LAST) begin
          d.st  = C_DONE;
          d.out = q.pow ? ((|q.num[63:16]) ? 16'hffff : q.num[15:0]) : d.res[15:0];
        end
      end
      C_DONE: begin
        d.st = C_IDLE;
      end
    endcase
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign cif.busy   = (q.st != C_IDLE);
  assign cif.done   = (q.st == C_DONE);
  assign cif.result = q.out;
  // ******************************
  // Checks
  // ******************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_go;
    cif.start && !cif.busy && cif.fund != '0;
  endsequence
  property p_zero;
    (cif.start && !cif.busy && cif.fund == '0) |=> cif.done && cif.result == '0;
  endproperty
  a_zero: assert property (p_zero) else $error("zero fundamental not zero");
  property p_lat;
    s_go |-> ##81 cif.done;
  endproperty
  a_lat: assert property (p_lat) else $error("ratio latency wrong");
endmodule
`default_nettype wire

// ==== rtl/hdm_calc_if.sv ====
// Purpose: Carrier between the monitor and its ratio calculator
// Assumes: One clock domain
// Notes:   start is a one-cycle pulse, done likewise
`timescale 1ns/10ps
`default_nettype none
interface hdm_calc_if;
  logic                         start;
  logic                         power;
  logic [hdm_pkg::SUM_W-1:0]    sum;
  logic [hdm_pkg::MAG_W-1:0]    fund;
  logic                         busy;
  logic                         done;
  logic [hdm_pkg::THD_W-1:0]    result;
  modport calc (input start, power, sum, fund, output busy, done, result);
  modport ctl  (output start, power, sum, fund, input busy, done, result);
endinterface
`default_nettype wire

// ==== rtl/hdm_monitor.sv ====
// Purpose: Current harmonic distortion monitor with three elements
// Assumes: Spectrum words arrive one channel at a time, index 0 to 31
// Notes:   Registers over classic Wishbone, block pin synchronised
// Behaviour
// - Use harmonics up to the thirty-first
// - Power ratio: harmonic power over fundamental power
// - Amplitude ratio: square root of power ratio
// - One method for all; 1 amplitude, 2 power
// - Method is outside the setting groups
// - 20 ms average kept as pre-fault value
// - Per-element enable, 0 enabled, disabled never acts
// - Per-element threshold in 0.01 % steps, 10.00 %
// - Phase element picks up on any phase
// - Release below 97 % of threshold
// - Residual elements use their own input
// - Start only while block is inactive
// - Start, alarm and blocked outputs per element
// - Eight setting groups, one live selector
// - Every output change emits stamped event
// - Clearable start, alarm and blocked counters
// - Condition code: normal, start, alarm, blocked
// - Alarm after set delay in 5 ms steps
// - Block at pick-up gives blocked, resets start
//
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module hdm_monitor #(
  parameter int MS_CYCLES = hdm_pkg::MS_CYCLES
) (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [11:0] wb_adr_in,
  input  wire logic [3:0]  wb_sel_in,
  input  wire logic [31:0] wb_dat_in,
  output var  logic [31:0] wb_dat_out,
  output var  logic        wb_ack_out,
  input  wire logic        spec_valid_in,
  input  wire logic [2:0]  spec_chan_in,
  input  wire logic [4:0]  spec_index_in,
  input  wire logic [15:0] spec_mag_in,
  output var  logic        spec_ready_out,
  input  wire logic        block_in,
  output var  logic [2:0]  start_out,
  output var  logic [2:0]  alarm_out,
  output var  logic [2:0]  blocked_out,
  output var  logic [1:0]  cond_out,
  output var  logic        event_valid_out,
  output var  logic [4:0]  event_code_out,
  output var  logic [31:0] event_stamp_out,
  output var  logic [15:0] event_data_out
);
  if (MS_CYCLES < 2 || MS_CYCLES > 65536) begin : g_chk
    $error("MS_CYCLES out of range");
  end
  localparam int G = hdm_pkg::NGRP;
  localparam int E = hdm_pkg::NEL;
  localparam int C = hdm_pkg::NCH;
  localparam logic [15:0] MS_LAST = 16'(MS_CYCLES - 1);
  typedef struct packed {
    logic                                  ack;
    logic [31:0]                           rdat;
    logic [1:0]                            meth;
    logic [2:0]                            grp;
    logic [G-1:0][E-1:0][15:0]             thr;
    logic [G-1:0][E-1:0]                   dis;
    logic [G-1:0][E-1:0][19:0]             dly;
    logic                                  b1;
    logic                                  b2;
    logic [hdm_pkg::SUM_W-1:0]             sum;
    logic [15:0]                           fund;
    logic                                  ready;
    logic                                  launch;
    logic [2:0]                            cch;
    logic [C-1:0][15:0]                    thd;
    logic [C-1:0][hdm_pkg::HIST-1:0][15:0] hist;
    logic [C-1:0][1:0]                     hptr;
    logic [E-1:0]                          pick;
    logic [E-1:0]                          start;
    logic [E-1:0]                          alarm;
    logic [E-1:0]                          blk;
    logic [E-1:0][19:0]                    tmr;
    logic [15:0]                           mscnt;
    logic [E-1:0][2:0]                     sub;
    logic [31:0]                           stamp;
    logic [8:0]                            pend;
    logic                                  ev_v;
    logic [4:0]                            ev_code;
    logic [31:0]                           ev_stamp;
    logic [15:0]                           ev_data;
    logic [15:0]                           cnt_s;
    logic [15:0]                           cnt_a;
    logic [15:0]                           cnt_b;
    logic [1:0]                            cond;
  } hdm_mon_t;
  hdm_mon_t                q;
  hdm_mon_t                d;
  logic [E-1:0][15:0]      thr_v;
  logic [E-1:0][19:0]      dly_v;
  logic [E-1:0]            en_v;
  logic [E-1:0]            gt_v;
  logic [E-1:0]            hold_v;
  logic [C-1:0][15:0]      avg_v;
  logic [E-1:0][15:0]      el_avg;
  logic [31:0]             sq;
  logic [31:0]             m;
  logic [31:0]             nv;
  logic [31:0]             rd;
  logic [8:0]              lev_q;
  logic [8:0]              chg;
  logic                    req;
  logic                    tick;
  logic                    found;
  logic                    tmr_ok;
  int                      idx;
  int                      el;
  hdm_calc_if cif ();
  hdm_calc u_calc (
    .clk_in   (clk_in),
    .rst_n_in (rst_n_in),
    .cif      (cif)
  );
  assign cif.start = q.launch;
  assign cif.power = (q.meth == hdm_pkg::METH_POW);
  assign cif.sum   = q.sum;
  assign cif.fund  = q.fund;
  function automatic int el_of(input int c);
    return (c < 3) ? 0 : c - 2;
  endfunction
  // ******************************
  // Next state
  // ******************************
  always_comb begin
    d        = q;
    d.launch = 1'b0;
    d.b1     = block_in;
    d.b2     = q.b1;
    thr_v    = q.thr[q.grp];
    dly_v    = q.dly[q.grp];
    en_v     = ~q.dis[q.grp];
    sq       = 32'(spec_mag_in) * 32'(spec_mag_in);
    m        = {{8{wb_sel_in[3]}}, {8{wb_sel_in[2]}}, {8{wb_sel_in[1]}}, {8{wb_sel_in[0]}}};
    nv       = '0;
    rd       = '0;
    idx      = 0;
    el       = 0;
    found    = 1'b0;
    req      = wb_cyc_in && wb_stb_in && !q.ack;
    d.ack    = req;
    // Spectrum intake
    if (spec_valid_in && q.ready) begin
      if (spec_index_in == hdm_pkg::HARM_DC) begin
        d.sum = '0;
      end else if (spec_index_in == hdm_pkg::HARM_FUND) begin
        d.fund = spec_mag_in;
      end else begin
        d.sum = q.sum + hdm_pkg::SUM_W'(sq);
      end
      if (spec_index_in == hdm_pkg::HARM_LAST && spec_chan_in < 3'(C)) begin
        d.ready  = 1'b0;
        d.launch = 1'b1;
        d.cch    = spec_chan_in;
      end
    end
    if (cif.done) begin
      d.thd[q.cch]                 = cif.result;
      d.hist[q.cch][q.hptr[q.cch]] = cif.result;
      d.hptr[q.cch]                = q.hptr[q.cch] + 2'h1;
      d.ready                      = 1'b1;
      d.sum                        = '0;
    end
    for (int c = 0; c < C; c++) begin
      avg_v[c] = 16'((18'(q.hist[c][0]) + 18'(q.hist[c][1])
               + 18'(q.hist[c][2]) + 18'(q.hist[c][3])) >> 2);
    end
    el_avg[0] = (avg_v[0] > avg_v[1]) ? avg_v[0] : avg_v[1];
    el_avg[0] = (avg_v[2] > el_avg[0]) ? avg_v[2] : el_avg[0];
    el_avg[1] = avg_v[3];
    el_avg[2] = avg_v[4];
    // Threshold comparison with fixed hysteresis
    gt_v   = '0;
    hold_v = '0;
    for (int c = 0; c < C; c++) begin
      el            = el_of(c);
      gt_v[el]      = gt_v[el] | (q.thd[c] > thr_v[el]);
      hold_v[el]    = hold_v[el] | (23'(q.thd[c]) * 23'(hdm_pkg::REL_DEN)
                    >= 23'(thr_v[el]) * 23'(hdm_pkg::REL_NUM));
    end
    // Time base
    tick    = (q.mscnt == MS_LAST);
    d.mscnt = tick ? 16'h0 : q.mscnt + 16'h1;
    if (tick) begin
      d.stamp = q.stamp + 32'h1;
    end
    for (int e = 0; e < E; e++) begin
      d.pick[e]  = en_v[e] && (q.pick[e] ? hold_v[e] : gt_v[e]);
      d.start[e] = d.pick[e] && !q.b2;
      d.blk[e]   = d.pick[e] && q.b2;
      if (!d.start[e]) begin
        d.tmr[e] = '0;
        d.sub[e] = '0;
      end else if (tick && q.tmr[e] < dly_v[e]) begin
        if (q.sub[e] == hdm_pkg::STEP_LAST) begin
          d.sub[e] = 3'h0;
          d.tmr[e] = q.tmr[e] + 20'h1;
        end else begin
          d.sub[e] = q.sub[e] + 3'h1;
        end
      end
      d.alarm[e] = d.start[e] && (q.tmr[e] >= dly_v[e]);
    end
    // Event queue, lowest index first
    lev_q = {q.blk, q.alarm, q.start};
    chg   = {d.blk, d.alarm, d.start} ^ lev_q;
    for (int i = 0; i < 9; i++) begin
      if (q.pend[i] && !found) begin
        found = 1'b1;
        idx   = i;
      end
    end
    d.pend = q.pend;
    d.ev_v = found;
    if (found) begin
      d.pend[idx] = 1'b0;
      d.ev_code   = {2'(idx / 3), 2'(idx % 3), lev_q[idx]};
      d.ev_stamp  = q.stamp;
      d.ev_data   = el_avg[idx % 3];
    end
    d.pend = d.pend | chg;
    // Counters, an event in the clearing cycle survives
    if (req && wb_we_in && wb_adr_in == hdm_pkg::A_CLR) begin
      d.cnt_s = '0;
      d.cnt_a = '0;
      d.cnt_b = '0;
    end
    d.cnt_s = d.cnt_s + 16'(|(d.start & ~q.start));
    d.cnt_a = d.cnt_a + 16'(|(d.alarm & ~q.alarm));
    d.cnt_b = d.cnt_b + 16'(|(d.blk & ~q.blk));
    if (|d.blk) begin
      d.cond = hdm_pkg::COND_BLOCKED;
    end else if (|d.alarm) begin
      d.cond = hdm_pkg::COND_ALARM;
    end else if (|d.start) begin
      d.cond = hdm_pkg::COND_START;
    end else begin
      d.cond = hdm_pkg::COND_NORMAL;
    end
    // Register access
    if (wb_adr_in[11:7] == hdm_pkg::A_THR[11:7] && wb_adr_in[3:2] != 2'h3) begin
      rd = 32'({q.dis[wb_adr_in[6:4]][wb_adr_in[3:2]], q.thr[wb_adr_in[6:4]][wb_adr_in[3:2]]});
      nv = (rd & ~m) | (wb_dat_in & m);
      if (req && wb_we_in) begin
        d.thr[wb_adr_in[6:4]][wb_adr_in[3:2]] = nv[15:0];
        d.dis[wb_adr_in[6:4]][wb_adr_in[3:2]] = nv[hdm_pkg::THR_DIS_BIT];
      end
    end else if (wb_adr_in[11:7] == hdm_pkg::A_DLY[11:7] && wb_adr_in[3:2] != 2'h3) begin
      rd = 32'(q.dly[wb_adr_in[6:4]][wb_adr_in[3:2]]);
      nv = (rd & ~m) | (wb_dat_in & m);
      if (req && wb_we_in) begin
        d.dly[wb_adr_in[6:4]][wb_adr_in[3:2]] = nv[19:0];
      end
    end else if (wb_adr_in[11:5] == hdm_pkg::A_THD[11:5] && wb_adr_in[4:2] < 3'(C)) begin
      rd = 32'(q.thd[wb_adr_in[4:2]]);
    end else if (wb_adr_in[11:5] == hdm_pkg::A_AVG[11:5] && wb_adr_in[4:2] < 3'(C)) begin
      rd = 32'(avg_v[wb_adr_in[4:2]]);
    end else begin
      unique case (wb_adr_in)
        hdm_pkg::A_CTRL: begin
          rd = 32'({q.grp, 2'h0, q.meth});
          nv = (rd & ~m) | (wb_dat_in & m);
          if (req && wb_we_in) begin
            d.grp = nv[hdm_pkg::CTRL_GRP_LSB +: 3];
            if (nv[1:0] == hdm_pkg::METH_AMP || nv[1:0] == hdm_pkg::METH_POW) begin
              d.meth = nv[1:0];
            end
          end
        end
        hdm_pkg::A_STAT:  rd = 32'({q.b2, q.blk, q.alarm, q.start, q.cond});
        hdm_pkg::A_CNT_S: rd = 32'(q.cnt_s);
        hdm_pkg::A_CNT_A: rd = 32'(q.cnt_a);
        hdm_pkg::A_CNT_B: rd = 32'(q.cnt_b);
        hdm_pkg::A_STAMP: rd = q.stamp;
        default:          rd = '0;
      endcase
    end
    if (req && !wb_we_in) begin
      d.rdat = rd;
    end
  end
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      q       <= '0;
      q.meth  <= hdm_pkg::METH_AMP;
      q.thr   <= {(G * E){hdm_pkg::THR_RST}};
      q.dly   <= {(G * E){hdm_pkg::DLY_RST}};
      q.ready <= 1'b1;
    end else begin
      q <= d;
    end
  end
  assign wb_dat_out      = q.rdat;
  assign wb_ack_out      = q.ack;
  assign spec_ready_out  = q.ready;
  assign start_out       = q.start;
  assign alarm_out       = q.alarm;
  assign blocked_out     = q.blk;
  assign cond_out        = q.cond;
  assign event_valid_out = q.ev_v;
  assign event_code_out  = q.ev_code;
  assign event_stamp_out = q.ev_stamp;
  assign event_data_out  = q.ev_data;
  assign tmr_ok          = q.tmr[0] >= dly_v[0];
  // ******************************
  // Checks
  // ******************************
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  property p_dis;
    ((q.start | q.blk | q.alarm) & ~$past(en_v)) == '0;
  endproperty
  a_dis: assert property (p_dis) else $error("disabled element active");
  property p_blk;
    (|q.blk) |-> $past(q.b2) && q.start == '0;
  endproperty
  a_blk: assert property (p_blk) else $error("blocked without block");
  property p_start;
    (|q.start) |-> !$past(q.b2);
  endproperty
  a_start: assert property (p_start) else $error("start while blocked");
  property p_alm;
    (q.alarm & ~q.start) == '0;
  endproperty
  a_alm: assert property (p_alm) else $error("alarm without start");
  property p_dly;
    $rose(q.alarm[0]) |-> $past(tmr_ok);
  endproperty
  a_dly: assert property (p_dly) else $error("alarm before delay");
  property p_cond;
    (|q.blk) |-> q.cond == hdm_pkg::COND_BLOCKED;
  endproperty
  a_cond: assert property (p_cond) else $error("condition code wrong");
  property p_hyst;
    (q.pick[1] && hold_v[1] && en_v[1]) |=> q.pick[1];
  endproperty
  a_hyst: assert property (p_hyst) else $error("early release");
  property p_pick;
    (gt_v[2] && en_v[2]) |=> q.pick[2];
  endproperty
  a_pick: assert property (p_pick) else $error("missed pick-up");
  sequence s_req;
    wb_cyc_in && wb_stb_in && !q.ack;
  endsequence
  property p_ack;
    s_req |=> q.ack ##1 !q.ack;
  endproperty
  a_ack: assert property (p_ack) else $error("ack not single");
  property p_evt;
    $changed(q.start[0]) |-> ##[0:9] q.ev_v;
  endproperty
  a_evt: assert property (p_evt) else $error("event missing");
endmodule
`default_nettype wire

// ==== rtl/hdm_pkg.sv ====
// Purpose: Shared constants of the harmonic distortion monitor
// Assumes: 20 MHz system clock, 32-bit classic Wishbone
// Notes:   Offsets are byte addresses
package hdm_pkg;
  localparam int NCH    = 5;
  localparam int NEL    = 3;
  localparam int NGRP   = 8;
  localparam int MAG_W  = 16;
  localparam int THD_W  = 16;
  localparam int DLY_W  = 20;
  localparam int CNT_W  = 16;
  localparam int SUM_W  = 37;
  localparam int CLK_HZ = 20_000_000;
  localparam int TICK_MS   = 1;
  localparam int MS_CYCLES = CLK_HZ / 1000 * TICK_MS;
  localparam int STEP_MS   = 5;
  localparam int AVG_MS    = 20;
  localparam int HIST      = AVG_MS / STEP_MS;
  localparam logic [2:0] STEP_LAST = 3'(STEP_MS - 1);
  localparam logic [4:0] HARM_DC   = 5'h00;
  localparam logic [4:0] HARM_FUND = 5'h01;
  localparam logic [4:0] HARM_LAST = 5'h1f;
  localparam logic [1:0] METH_AMP  = 2'h1;
  localparam logic [1:0] METH_POW  = 2'h2;
  localparam logic [15:0] THR_RST  = 16'h03e8;
  localparam logic [19:0] DLY_RST  = 20'h007d0;
  localparam logic [6:0] REL_NUM   = 7'h61;
  localparam logic [6:0] REL_DEN   = 7'h64;
  localparam logic [63:0] SCALE_POW = 64'h0000_0000_0000_2710;
  localparam logic [63:0] SCALE_AMP = 64'h0000_0000_05f5_e100;
  localparam logic [31:0] SQRT_ONE  = 32'h4000_0000;
  localparam logic [6:0] DIV_LAST  = 7'h3f;
  localparam logic [6:0] SQRT_LAST = 7'h0f;
  localparam logic [1:0] COND_NORMAL  = 2'h0;
  localparam logic [1:0] COND_START   = 2'h1;
  localparam logic [1:0] COND_ALARM   = 2'h2;
  localparam logic [1:0] COND_BLOCKED = 2'h3;
  localparam logic [11:0] A_CTRL  = 12'h000;
  localparam logic [11:0] A_STAT  = 12'h004;
  localparam logic [11:0] A_CLR   = 12'h008;
  localparam logic [11:0] A_CNT_S = 12'h00c;
  localparam logic [11:0] A_CNT_A = 12'h010;
  localparam logic [11:0] A_CNT_B = 12'h014;
  localparam logic [11:0] A_STAMP = 12'h018;
  localparam logic [11:0] A_THD   = 12'h040;
  localparam logic [11:0] A_AVG   = 12'h060;
  localparam logic [11:0] A_THR   = 12'h100;
  localparam logic [11:0] A_DLY   = 12'h200;
  localparam int CTRL_GRP_LSB = 4;
  localparam int THR_DIS_BIT  = 16;
endpackage

// ==== verification/hdm_monitor_tb.sv ====
// Purpose: Self-checking bench of the distortion monitor
// Assumes: One ms shortened to 10 cycles
// Notes:   Scenarios run in sequence and share state
`timescale 1ns/10ps
`default_nettype none
module hdm_monitor_tb;
  logic        clk_in = 1'b0, rst_n_in = 1'b0, block_in = 1'b0;
  logic        wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [11:0] wb_adr = 12'h000;
  logic [31:0] wb_dat = 32'h0, wb_dat_out, ev_stamp;
  logic        wb_ack_out, spec_valid, spec_ready_out, ev_valid;
  logic [2:0]  spec_chan, start_out, alarm_out, blocked_out;
  logic [4:0]  spec_index, ev_code;
  logic [15:0] spec_mag, ev_data;
  logic [1:0]  cond_out;
  int          errors = 0, checks_done = 0, n_ev = 0;
  logic [31:0] first_stamp = 32'h0, last_stamp = 32'h0;
  logic [4:0]  last_code = 5'h00;
  logic [15:0] last_data = 16'h0000;
  always #25 clk_in = ~clk_in;
  always @(posedge clk_in) begin
    if (ev_valid === 1'b1) begin
      n_ev       <= n_ev + 1;
      last_code  <= ev_code;
      last_data  <= ev_data;
      last_stamp <= ev_stamp;
      if (n_ev == 0) first_stamp <= ev_stamp;
    end
  end
  hdm_monitor #(.MS_CYCLES(10)) u_hdm_monitor (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .wb_cyc_in(wb_cyc), .wb_stb_in(wb_stb), .wb_we_in(wb_we), .wb_adr_in(wb_adr),
    .wb_sel_in(4'hf), .wb_dat_in(wb_dat), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .spec_valid_in(spec_valid), .spec_chan_in(spec_chan), .spec_index_in(spec_index),
    .spec_mag_in(spec_mag), .spec_ready_out(spec_ready_out), .block_in(block_in),
    .start_out(start_out), .alarm_out(alarm_out), .blocked_out(blocked_out),
    .cond_out(cond_out), .event_valid_out(ev_valid), .event_code_out(ev_code),
    .event_stamp_out(ev_stamp), .event_data_out(ev_data));
  hdm_spec_src u_hdm_spec_src (.clk_in(clk_in), .ready_in(spec_ready_out),
    .valid_out(spec_valid), .chan_out(spec_chan), .index_out(spec_index), .mag_out(spec_mag));
  task automatic results();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wb(input logic we, input logic [11:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n;
    n = 0;
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we <= we;
    wb_adr <= a;
    wb_dat <= d;
    do begin
      @(posedge clk_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 100);
    if (n >= 100) begin
      errors++;
      results();
    end
    r = wb_dat_out;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(posedge clk_in);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    wb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    wb(1'b0, a, 32'h0, r);
    chk($sformatf("register %h", a), exp, r);
  endtask
  task automatic spec(input logic [2:0] ch, input logic [15:0] f, input logic [15:0] h);
    int n;
    n = 0;
    u_hdm_spec_src.send(ch, f, h);
    repeat (2) @(posedge clk_in);
    while (spec_ready_out !== 1'b1) begin
      @(posedge clk_in);
      n++;
      if (n > 300) begin
        errors++;
        results();
      end
    end
    repeat (4) @(posedge clk_in);
  endtask
  task automatic t_reset();
    chk("ready", 32'h1, 32'(spec_ready_out));
    chk("start", 32'h0, 32'(start_out));
    rd(12'h000, 32'h1);
    rd(12'h100, 32'h3e8);
    rd(12'h200, 32'h7d0);
    rd(12'hffc, 32'h0);
    $display("test reset done");
  endtask
  task automatic t_residual();
    wr(12'h000, 32'h2);
    spec(3'h3, 16'h0064, 16'h0014);
    rd(12'h04c, 32'h190);
    chk("start", 32'h0, 32'(start_out));
    wr(12'h000, 32'h13);
    rd(12'h000, 32'h12);
    wr(12'h000, 32'h11);
    spec(3'h3, 16'h0064, 16'h0014);
    rd(12'h04c, 32'h7d0);
    chk("start", 32'h2, 32'(start_out));
    chk("cond", 32'h1, 32'(cond_out));
    spec(3'h3, 16'h0064, 16'h000a);
    chk("start", 32'h2, 32'(start_out));
    spec(3'h3, 16'h0064, 16'h0009);
    chk("start", 32'h0, 32'(start_out));
    spec(3'h3, 16'h0000, 16'h0014);
    rd(12'h04c, 32'h0);
    rd(12'h06c, 32'h3cf);
    $display("test residual done");
  endtask
  task automatic t_phase();
    wr(12'h210, 32'h1);
    spec(3'h1, 16'h0064, 16'h0014);
    chk("start", 32'h1, 32'(start_out));
    block_in <= 1'b1;
    repeat (5) @(posedge clk_in);
    chk("start", 32'h0, 32'(start_out));
    chk("blocked", 32'h1, 32'(blocked_out));
    chk("cond", 32'h3, 32'(cond_out));
    block_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    chk("alarm", 32'h0, 32'(alarm_out));
    repeat (110) @(posedge clk_in);
    chk("alarm", 32'h1, 32'(alarm_out));
    chk("cond", 32'h2, 32'(cond_out));
    wr(12'h110, 32'hbb8);
    spec(3'h1, 16'h0064, 16'h0014);
    chk("alarm", 32'h0, 32'(alarm_out));
    wr(12'h110, 32'h103e8);
    spec(3'h1, 16'h0064, 16'h0014);
    chk("start", 32'h0, 32'(start_out));
    repeat (20) @(posedge clk_in);
    chk("events", 32'd10, 32'(n_ev));
    chk("event code", 32'h08, 32'(last_code));
    chk("event data", 32'h1f4, 32'(last_data));
    chk("stamp order", 32'h1, 32'(last_stamp > first_stamp));
    $display("test phase done");
  endtask
  task automatic t_count();
    rd(12'h00c, 32'h3);
    rd(12'h010, 32'h1);
    rd(12'h014, 32'h1);
    wr(12'h008, 32'h1);
    rd(12'h00c, 32'h0);
    spec(3'h4, 16'h0064, 16'h0014);
    chk("start", 32'h4, 32'(start_out));
    rd(12'h00c, 32'h1);
    $display("test counters done");
  endtask
  initial begin
    repeat (10) @(posedge clk_in);
    rst_n_in <= 1'b1;
    @(posedge clk_in);
    t_reset();
    t_residual();
    t_phase();
    t_count();
    results();
  end
endmodule
`default_nettype wire

// ==== verification/hdm_spec_src.sv ====
// Purpose: Spectral measurement stage model feeding the monitor
// Assumes: Same clock as the monitor
// Notes:   Idle magnitude toggles so stale data is never seen
`timescale 1ns/10ps
`default_nettype none
module hdm_spec_src (
  input  wire logic        clk_in,
  input  wire logic        ready_in,
  output var  logic        valid_out,
  output var  logic [2:0]  chan_out,
  output var  logic [4:0]  index_out,
  output var  logic [15:0] mag_out
);
  initial begin
    valid_out = 1'b0;
    chan_out = 3'h0;
    index_out = 5'h00;
    mag_out = 16'h0000;
  end
  // One 32-word spectrum, index 0 to 31, held until taken
  task automatic send(input logic [2:0] ch, input logic [15:0] fund, input logic [15:0] harm);
    for (int i = 0; i < 32; i++) begin
      valid_out <= 1'b1;
      chan_out <= ch;
      index_out <= 5'(i);
      mag_out <= (i == 1) ? fund : ((i == 2) ? harm : 16'h0000);
      @(posedge clk_in);
      for (int w = 0; w < 200 && ready_in !== 1'b1; w++) @(posedge clk_in);
    end
    valid_out <= 1'b0;
    mag_out <= ~mag_out;
  endtask
endmodule
`default_nettype wire
